/* verilog/fdc_param_pkg.sv */
// Constants for the floppy command parameter decoder.
// Assumes one 100 MHz clock and an 8-bit register port.
package fdc_param_pkg;
  localparam int CLOCK_PERIOD_NS = 10;
  // One head load / unload step, 1 ms
  localparam int HEAD_STEP_NS = 1000000;
  localparam int HEAD_STEP_CYCLES = HEAD_STEP_NS / CLOCK_PERIOD_NS;

  localparam logic [3:0] ADDR_COMMAND = 4'h0;
  localparam logic [3:0] ADDR_DRIVE = 4'h1;
  localparam logic [3:0] ADDR_SIZE_CODE = 4'h2;
  localparam logic [3:0] ADDR_SHORT_LEN = 4'h3;
  localparam logic [3:0] ADDR_LAST_SECTOR = 4'h4;
  localparam logic [3:0] ADDR_GAP3 = 4'h5;
  localparam logic [3:0] ADDR_GAP2 = 4'h6;
  localparam logic [3:0] ADDR_CONFIG = 4'h7;
  localparam logic [3:0] ADDR_SETTLE = 4'h8;
  localparam logic [3:0] ADDR_RELEASE = 4'h9;
  localparam logic [3:0] ADDR_FIRST_SECTOR = 4'hA;
  localparam logic [3:0] ADDR_CYLINDER = 4'hB;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  localparam logic [3:0] ADDR_CRC_LOW = 4'hD;
  localparam logic [3:0] ADDR_CRC_HIGH = 4'hE;

  // Command register fields
  localparam int CMD_START_BIT = 7;
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_VERIFY = 2'h2;
  // Drive register fields
  localparam int DRIVE_HEAD_BIT = 2;
  // Config register fields
  localparam int CFG_COUNT_BIT = 0;
  localparam int CFG_QUEUE_N_BIT = 1;
  localparam int CFG_SEEK_BIT = 2;
  localparam int CFG_PERP_BIT = 3;
  localparam logic [7:0] CONFIG_RESET = 8'h02;
  localparam logic [7:0] SHORT_LEN_RESET = 8'hFF;

  localparam logic [14:0] BASE_SECTOR_BYTES = 15'h0080;
  localparam logic [2:0] MAX_SIZE_CODE = 3'h7;
  localparam logic [7:0] GAP2_DEFAULT = 8'h16;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;

  typedef enum logic [2:0] {ST_IDLE, ST_SEEK, ST_SETTLE, ST_XFER, ST_GAP, ST_RELEASE} phase_t;
endpackage

/* verilog/fdc_param_decode.sv */
// Parameter decoder and sector sequencer of the floppy controller.
// Assumes medium byte slots, seek completion and host bytes come from
// logic on the same clock; registers sit on a plain 8-bit port.
// How it works
// - Two-bit drive field, high bit first, selects drives 0 to 3.
// - Size code zero means 128-byte sector, short length sets bytes moved.
// - Read bytes past the short length are read but not passed on.
// - Write bytes past the short length are written as zero.
// - CRC covers the whole physical sector, padding and dropped bytes included.
// - Nonzero size code ignores the short length; host should program FF.
// - With count enable set, verify's short length byte is sectors to verify.
// - Queue enable is active low; 1 disables and is the default.
// - Implied seek on means seek before read, write or verify; off means none.
// - Last track sector number ends the transfer.
// - Perpendicular mode uses the gap parameter for the second gap length.
// - Gap length parameter sets the third gap between sectors.
// - Head parameter selects disk side 0 or 1 as in the sector ID.
// - Wait the head settle delay after loading before any transfer.
// - Wait the head release delay after execution before unloading.
// - Nonzero code gives 128 times two to the code bytes, up to 16K.
`timescale 1ns/1ns
module fdc_param_decode #(
  parameter int HEAD_STEP = fdc_param_pkg::HEAD_STEP_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic [3:0] drive_enable,
  output logic head_side_select,
  output logic head_load,
  output logic queue_enabled,
  output logic seek_request,
  output logic [7:0] seek_cylinder,
  input wire logic seek_done,
  output logic [7:0] gap2_length,
  output logic [7:0] gap3_length,
  input wire logic byte_slot,
  input wire logic [7:0] disk_byte_in,
  output logic [7:0] disk_byte_out,
  output logic disk_write_gate,
  output logic [7:0] host_byte_out,
  output logic host_byte_valid,
  input wire logic [7:0] host_byte_in,
  output logic host_byte_take,
  output logic busy
);

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ data[i]) begin
        c = {c[14:0], 1'b0} ^ fdc_param_pkg::CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  logic [7:0] command;
  logic [7:0] drive;
  logic [2:0] size_code;
  logic [7:0] short_transfer_length;
  logic [7:0] last_track_sector;
  logic [7:0] inter_sector_gap_length;
  logic [7:0] gap2_param;
  logic [7:0] cfg_word;
  logic [7:0] head_settle_delay;
  logic [7:0] head_release_delay;
  logic [7:0] first_sector;
  logic [7:0] cylinder;
  fdc_param_pkg::phase_t phase;
  logic [7:0] sector;
  logic [7:0] sectors_done;
  logic [14:0] byte_index;
  logic [7:0] gap_count;
  logic [31:0] step_count;
  logic [7:0] steps;
  logic [15:0] crc;
  logic [15:0] last_crc;
  logic idle;
  logic start;
  logic [1:0] cmd_kind;
  logic verify_count_enable;
  logic implied_seek_on;
  logic perpendicular;
  logic [14:0] phys_len;
  logic [14:0] xfer_len;
  logic in_window;
  logic last_byte;
  logic final_sector;
  logic step_tick;
  logic [7:0] medium_byte;

  assign idle = phase == fdc_param_pkg::ST_IDLE;
  // Writes while busy are dropped so the running command sees stable values
  assign start = idle && reg_write && reg_addr == fdc_param_pkg::ADDR_COMMAND
    && reg_wdata[fdc_param_pkg::CMD_START_BIT];
  assign cmd_kind = command[1:0];
  assign verify_count_enable = cfg_word[fdc_param_pkg::CFG_COUNT_BIT];
  assign implied_seek_on = cfg_word[fdc_param_pkg::CFG_SEEK_BIT];
  assign perpendicular = cfg_word[fdc_param_pkg::CFG_PERP_BIT];

  // Sector length doubles per code step, 16K at code 7
  assign phys_len = fdc_param_pkg::BASE_SECTOR_BYTES << size_code;
  // Short length applies only at code zero; otherwise the full sector moves
  assign xfer_len = (size_code == 3'h0) ? {7'h00, short_transfer_length} : phys_len;
  assign in_window = byte_index < xfer_len;
  assign last_byte = byte_index == phys_len - 15'h0001;
  assign final_sector = (cmd_kind == fdc_param_pkg::CMD_VERIFY && verify_count_enable)
    ? (sectors_done + 8'h01 >= short_transfer_length)
    : (sector == last_track_sector);
  assign step_tick = step_count == 32'(HEAD_STEP - 1);
  assign medium_byte = (cmd_kind == fdc_param_pkg::CMD_WRITE)
    ? (in_window ? host_byte_in : 8'h00)
    : disk_byte_in;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      command <= 8'h00;
      drive <= 8'h00;
      size_code <= 3'h0;
      short_transfer_length <= fdc_param_pkg::SHORT_LEN_RESET;
      last_track_sector <= 8'h00;
      inter_sector_gap_length <= 8'h00;
      gap2_param <= 8'h00;
      cfg_word <= fdc_param_pkg::CONFIG_RESET;
      head_settle_delay <= 8'h00;
      head_release_delay <= 8'h00;
      first_sector <= 8'h00;
      cylinder <= 8'h00;
    end else if (reg_write && idle) begin
      case (reg_addr)
        fdc_param_pkg::ADDR_COMMAND: command <= reg_wdata;
        fdc_param_pkg::ADDR_DRIVE: drive <= reg_wdata;
        fdc_param_pkg::ADDR_SIZE_CODE: size_code <= reg_wdata[2:0];
        fdc_param_pkg::ADDR_SHORT_LEN: short_transfer_length <= reg_wdata;
        fdc_param_pkg::ADDR_LAST_SECTOR: last_track_sector <= reg_wdata;
        fdc_param_pkg::ADDR_GAP3: inter_sector_gap_length <= reg_wdata;
        fdc_param_pkg::ADDR_GAP2: gap2_param <= reg_wdata;
        fdc_param_pkg::ADDR_CONFIG: cfg_word <= {4'h0, reg_wdata[3:0]};
        fdc_param_pkg::ADDR_SETTLE: head_settle_delay <= reg_wdata;
        fdc_param_pkg::ADDR_RELEASE: head_release_delay <= reg_wdata;
        fdc_param_pkg::ADDR_FIRST_SECTOR: first_sector <= reg_wdata;
        fdc_param_pkg::ADDR_CYLINDER: cylinder <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Sequencer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase <= fdc_param_pkg::ST_IDLE;
    end else begin
      case (phase)
        fdc_param_pkg::ST_IDLE: begin
          if (start) begin
            if (reg_wdata[fdc_param_pkg::CFG_SEEK_BIT - 2] == 1'b0 && implied_seek_on) begin
              phase <= fdc_param_pkg::ST_SEEK;
            end else if (implied_seek_on && reg_wdata[1:0] != 2'h3) begin
              phase <= fdc_param_pkg::ST_SEEK;
            end else begin
              phase <= fdc_param_pkg::ST_SETTLE;
            end
          end
        end
        fdc_param_pkg::ST_SEEK: begin
          if (seek_done) begin
            phase <= fdc_param_pkg::ST_SETTLE;
          end
        end
        fdc_param_pkg::ST_SETTLE: begin
          if (steps >= head_settle_delay) begin
            phase <= fdc_param_pkg::ST_XFER;
          end
        end
        fdc_param_pkg::ST_XFER: begin
          if (byte_slot && last_byte) begin
            phase <= final_sector ? fdc_param_pkg::ST_RELEASE : fdc_param_pkg::ST_GAP;
          end
        end
        fdc_param_pkg::ST_GAP: begin
          if (byte_slot && gap_count + 8'h01 >= inter_sector_gap_length) begin
            phase <= fdc_param_pkg::ST_XFER;
          end
        end
        fdc_param_pkg::ST_RELEASE: begin
          if (steps >= head_release_delay) begin
            phase <= fdc_param_pkg::ST_IDLE;
          end
        end
        default: phase <= fdc_param_pkg::ST_IDLE;
      endcase
    end
  end

  // Head settle / release timer, counted in whole steps
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      step_count <= 32'h00000000;
      steps <= 8'h00;
    end else if (phase == fdc_param_pkg::ST_SETTLE || phase == fdc_param_pkg::ST_RELEASE) begin
      step_count <= step_tick ? 32'h00000000 : step_count + 32'h00000001;
      if (step_tick && steps != 8'hFF) begin
        steps <= steps + 8'h01;
      end
      if (phase == fdc_param_pkg::ST_SETTLE && steps >= head_settle_delay) begin
        steps <= 8'h00;
        step_count <= 32'h00000000;
      end
    end else begin
      step_count <= 32'h00000000;
      steps <= 8'h00;
    end
  end

  // Sector and byte position
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sector <= 8'h00;
      sectors_done <= 8'h00;
      byte_index <= 15'h0000;
      gap_count <= 8'h00;
    end else if (start) begin
      sector <= first_sector;
      sectors_done <= 8'h00;
      byte_index <= 15'h0000;
      gap_count <= 8'h00;
    end else if (byte_slot && phase == fdc_param_pkg::ST_XFER) begin
      // Whole physical sector is walked even when fewer bytes reach the host
      byte_index <= last_byte ? 15'h0000 : byte_index + 15'h0001;
      gap_count <= 8'h00;
      if (last_byte) begin
        sector <= sector + 8'h01;
        sectors_done <= sectors_done + 8'h01;
      end
    end else if (byte_slot && phase == fdc_param_pkg::ST_GAP) begin
      gap_count <= gap_count + 8'h01;
    end
  end

  // CRC over every byte of each physical sector on the medium
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      crc <= fdc_param_pkg::CRC_INIT;
      last_crc <= 16'h0000;
    end else if (phase != fdc_param_pkg::ST_XFER) begin
      crc <= fdc_param_pkg::CRC_INIT;
    end else if (byte_slot) begin
      crc <= last_byte ? fdc_param_pkg::CRC_INIT : crc_step(crc, medium_byte);
      if (last_byte) begin
        last_crc <= crc_step(crc, medium_byte);
      end
    end
  end

  // Data paths
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      disk_byte_out <= 8'h00;
      host_byte_out <= 8'h00;
      host_byte_valid <= 1'b0;
      host_byte_take <= 1'b0;
    end else begin
      host_byte_valid <= 1'b0;
      host_byte_take <= 1'b0;
      if (byte_slot && phase == fdc_param_pkg::ST_XFER) begin
        if (cmd_kind == fdc_param_pkg::CMD_WRITE) begin
          disk_byte_out <= medium_byte;
          host_byte_take <= in_window;
        end else if (cmd_kind == fdc_param_pkg::CMD_READ && in_window) begin
          host_byte_out <= disk_byte_in;
          host_byte_valid <= 1'b1;
        end
      end
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        fdc_param_pkg::ADDR_COMMAND: reg_rdata <= {1'b0, command[6:0]};
        fdc_param_pkg::ADDR_DRIVE: reg_rdata <= drive;
        fdc_param_pkg::ADDR_SIZE_CODE: reg_rdata <= {5'h00, size_code};
        fdc_param_pkg::ADDR_SHORT_LEN: reg_rdata <= short_transfer_length;
        fdc_param_pkg::ADDR_LAST_SECTOR: reg_rdata <= last_track_sector;
        fdc_param_pkg::ADDR_GAP3: reg_rdata <= inter_sector_gap_length;
        fdc_param_pkg::ADDR_GAP2: reg_rdata <= gap2_param;
        fdc_param_pkg::ADDR_CONFIG: reg_rdata <= cfg_word;
        fdc_param_pkg::ADDR_SETTLE: reg_rdata <= head_settle_delay;
        fdc_param_pkg::ADDR_RELEASE: reg_rdata <= head_release_delay;
        fdc_param_pkg::ADDR_FIRST_SECTOR: reg_rdata <= sector;
        fdc_param_pkg::ADDR_CYLINDER: reg_rdata <= cylinder;
        fdc_param_pkg::ADDR_STATUS: reg_rdata <= {4'h0, !idle, 3'(phase)};
        fdc_param_pkg::ADDR_CRC_LOW: reg_rdata <= last_crc[7:0];
        fdc_param_pkg::ADDR_CRC_HIGH: reg_rdata <= last_crc[15:8];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Drive decode: high bit first
  always_comb begin
    drive_enable = 4'h0;
    drive_enable[drive[1:0]] = !idle;
  end

  assign head_side_select = drive[fdc_param_pkg::DRIVE_HEAD_BIT];
  assign head_load = phase == fdc_param_pkg::ST_SETTLE || phase == fdc_param_pkg::ST_XFER
    || phase == fdc_param_pkg::ST_GAP || phase == fdc_param_pkg::ST_RELEASE;
  assign queue_enabled = !cfg_word[fdc_param_pkg::CFG_QUEUE_N_BIT];
  assign seek_request = phase == fdc_param_pkg::ST_SEEK;
  assign seek_cylinder = cylinder;
  assign gap2_length = perpendicular ? gap2_param : fdc_param_pkg::GAP2_DEFAULT;
  assign gap3_length = inter_sector_gap_length;
  assign disk_write_gate = cmd_kind == fdc_param_pkg::CMD_WRITE && phase == fdc_param_pkg::ST_XFER;
  assign busy = !idle;

endmodule

/* dv/fdc_param_decode_chk.sv */
// Port checker for the floppy parameter decoder.
// Assumes byte slots from the medium are at least two cycles apart.
`timescale 1ns/1ns
module fdc_param_decode_chk (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [3:0] drive_enable,
  input wire logic head_side_select,
  input wire logic head_load,
  input wire logic seek_request,
  input wire logic seek_done,
  input wire logic [7:0] seek_cylinder,
  input wire logic [7:0] gap3_length,
  input wire logic byte_slot,
  input wire logic [7:0] host_byte_in,
  input wire logic [7:0] disk_byte_out,
  input wire logic disk_write_gate,
  input wire logic host_byte_valid,
  input wire logic host_byte_take,
  input wire logic busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_drive_onehot;
    busy ? $onehot(drive_enable) : drive_enable == 4'h0;
  endproperty
  a_drive_onehot: assert property (p_drive_onehot) else $error("drive enable not one-hot");
  property p_host_slot;
    host_byte_valid |-> $past(byte_slot) && !disk_write_gate;
  endproperty
  a_host_slot: assert property (p_host_slot) else $error("host byte without slot");
  property p_take_data;
    host_byte_take |-> disk_byte_out == $past(host_byte_in);
  endproperty
  a_take_data: assert property (p_take_data) else $error("host byte not written");
  property p_zero_pad;
    disk_write_gate && $past(disk_write_gate) && $past(byte_slot) && !host_byte_take |-> disk_byte_out == 8'h00;
  endproperty
  a_zero_pad: assert property (p_zero_pad) else $error("pad byte not zero");
  property p_seek_first;
    seek_request |-> !head_load;
  endproperty
  a_seek_first: assert property (p_seek_first) else $error("head loaded during seek");
  property p_seek_end;
    seek_request && seek_done |=> !seek_request;
  endproperty
  a_seek_end: assert property (p_seek_end) else $error("seek not ended");
  property p_settle_first;
    $rose(head_load) |-> !disk_write_gate && !host_byte_valid;
  endproperty
  a_settle_first: assert property (p_settle_first) else $error("transfer before settle");
  property p_release_last;
    $fell(head_load) |-> $fell(busy);
  endproperty
  a_release_last: assert property (p_release_last) else $error("head unloaded early");
  property p_hold_params;
    busy && $past(busy) |-> $stable(seek_cylinder) && $stable(gap3_length) && $stable(head_side_select);
  endproperty
  a_hold_params: assert property (p_hold_params) else $error("parameter changed while busy");
  c_read: cover property (host_byte_valid);
  c_write: cover property (host_byte_take);
  c_seek: cover property (seek_request && seek_done);
  c_done: cover property ($fell(busy));
endmodule
bind fdc_param_decode fdc_param_decode_chk i_chk (.clock, .arst_n, .drive_enable, .head_side_select, .head_load,
  .seek_request, .seek_done, .seek_cylinder, .gap3_length, .byte_slot, .host_byte_in, .disk_byte_out,
  .disk_write_gate, .host_byte_valid, .host_byte_take, .busy);

/* dv/fdc_medium_model.sv */
// Medium and seek model on the far side of the decoder.
// Assumes one clock; the host supplies a fixed write byte.
`timescale 1ns/1ns
module fdc_medium_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic slow_seek,
  input wire logic seek_request,
  output logic seek_done,
  output logic byte_slot,
  output logic [7:0] disk_byte_in,
  output logic [7:0] host_byte_in
);
  logic [1:0] slot_phase;
  logic [4:0] seek_wait;
  assign host_byte_in = 8'h5A;
  // The disk keeps spinning, so slots run free and data changes per slot
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      slot_phase <= 2'h0;
      byte_slot <= 1'b0;
      disk_byte_in <= 8'h00;
    end else begin
      slot_phase <= slot_phase + 2'h1;
      byte_slot <= (slot_phase == 2'h3);
      if (byte_slot) begin
        disk_byte_in <= disk_byte_in + 8'h01;
      end
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      seek_wait <= 5'h00;
      seek_done <= 1'b0;
    end else begin
      seek_done <= 1'b0;
      if (!seek_request) begin
        seek_wait <= 5'h00;
      end else if (!seek_done) begin
        seek_wait <= seek_wait + 5'h01;
        seek_done <= (seek_wait == (slow_seek ? 5'h14 : 5'h00));
      end
    end
  end
endmodule

/* dv/fdc_param_decode_test.sv */
// Self-checking bench for the floppy parameter decoder.
// Assumes the medium model supplies byte slots and seek completion.
`timescale 1ns/1ns
module fdc_param_decode_test;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic slow_seek = 1'b0;
  logic [7:0] reg_rdata, seek_cylinder, gap2_length, gap3_length, disk_byte_in, disk_byte_out;
  logic [7:0] host_byte_out, host_byte_in, v;
  logic [3:0] drive_enable;
  logic head_side_select, head_load, queue_enabled, seek_request, seek_done, byte_slot;
  logic disk_write_gate, host_byte_valid, host_byte_take, busy;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int nv, nt, nk, ns, nr, ng;
  always #5 clock = ~clock;
  fdc_param_decode #(.HEAD_STEP(4)) i_dut (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .drive_enable, .head_side_select, .head_load, .queue_enabled, .seek_request, .seek_cylinder,
    .seek_done, .gap2_length, .gap3_length, .byte_slot, .disk_byte_in, .disk_byte_out, .disk_write_gate,
    .host_byte_out, .host_byte_valid, .host_byte_in, .host_byte_take, .busy);
  fdc_medium_model i_model (.clock, .arst_n, .slow_seek, .seek_request, .seek_done, .byte_slot, .disk_byte_in,
    .host_byte_in);
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rng(string what, int lo, int hi, int got);
    check_count++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic bus(logic w, logic r, logic [3:0] a, logic [7:0] d);
    reg_write <= w;
    reg_read <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  // Data appears in the cycle after the strobe and holds until the next read strobe
  task automatic rd(logic [3:0] a);
    bus(1'b0, 1'b1, a, 8'h00);
    #1 v = reg_rdata;
  endtask
  task automatic setup(logic [7:0] code, sl, first, last, cfg, settle, rel, drv);
    wr(4'h2, code);
    wr(4'h3, sl);
    wr(4'hA, first);
    wr(4'h4, last);
    wr(4'h7, cfg);
    wr(4'h8, settle);
    wr(4'h9, rel);
    wr(4'h1, drv);
    wr(4'h5, 8'h02);
    wr(4'h6, 8'h2A);
  endtask
  // Status is polled every cycle, so phases are counted from the port side
  task automatic run_cmd(logic [7:0] cmd, logic [3:0] drv, logic head);
    logic [2:0] prev;
    int n;
    prev = 3'h0;
    n = 0;
    {nv, nt, nk, ns, nr, ng} = '0;
    wr(4'h0, cmd);
    bus(1'b0, 1'b1, 4'hC, 8'h00);
    do begin
      @(posedge clock);
      #1;
      n++;
      if (n == 1) chk("drive and head", {11'h0, head, drv}, {11'h0, head_side_select, drive_enable});
      if (host_byte_valid === 1'b1) nv++;
      // Model steps its byte on every slot, so the delivered byte is one behind
      if (host_byte_valid === 1'b1) chk("host byte", {8'h00, disk_byte_in - 8'h01}, {8'h00, host_byte_out});
      if (host_byte_take === 1'b1) nt++;
      if (reg_rdata[2:0] === 3'h1) nk++;
      if (reg_rdata[2:0] === 3'h2) ns++;
      if (reg_rdata[2:0] === 3'h5) nr++;
      if (reg_rdata[2:0] === 3'h4 && prev !== 3'h4) ng++;
      prev = reg_rdata[2:0];
    end while (reg_rdata[3] !== 1'b0 && n < 8000);
    bus(1'b0, 1'b0, 4'hC, 8'h00);
    chk("busy after command", 16'h0000, {15'h0, busy});
  endtask
  function automatic logic [15:0] crc_of(int taken);
    logic [15:0] c;
    logic [7:0] b;
    c = fdc_param_pkg::CRC_INIT;
    for (int i = 0; i < 128; i++) begin
      b = (i < taken) ? 8'h5A : 8'h00;
      for (int k = 7; k >= 0; k--) begin
        c = (c[15] ^ b[k]) ? ({c[14:0], 1'b0} ^ fdc_param_pkg::CRC_POLY) : {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction
  task automatic test_reset();
    rd(4'h7);
    chk("config reset", 16'h0002, {8'h00, v});
    rd(4'h3);
    chk("short length reset", 16'h00FF, {8'h00, v});
    rd(4'hF);
    chk("unmapped read", 16'h0000, {8'h00, v});
    chk("queue off", 16'h0000, {15'h0, queue_enabled});
    chk("gap2 default", 16'h0016, {8'h00, gap2_length});
    $display("test reset done");
  endtask
  task automatic test_read_multi();
    setup(8'h00, 8'h03, 8'h03, 8'h05, 8'h02, 8'h02, 8'h03, 8'h06);
    run_cmd(8'h80, 4'h4, 1'b1);
    chk("host bytes", 16'd9, 16'(nv));
    chk("gaps", 16'd2, 16'(ng));
    chk("seek cycles", 16'd0, 16'(nk));
    rng("settle cycles", 7, 9, ns);
    rng("release cycles", 11, 13, nr);
    chk("gap3 out", 16'h0002, {8'h00, gap3_length});
    $display("test read_multi done");
  endtask
  task automatic test_read_large();
    setup(8'h01, 8'h03, 8'h01, 8'h01, 8'h08, 8'h00, 8'h00, 8'h01);
    chk("queue on", 16'h0001, {15'h0, queue_enabled});
    chk("gap2 perpendicular", 16'h002A, {8'h00, gap2_length});
    run_cmd(8'h80, 4'h2, 1'b0);
    chk("host bytes", 16'd256, 16'(nv));
    $display("test read_large done");
  endtask
  task automatic test_write_pad();
    slow_seek <= 1'b1;
    setup(8'h00, 8'h02, 8'h01, 8'h01, 8'h06, 8'h00, 8'h00, 8'h00);
    wr(4'hB, 8'h37);
    run_cmd(8'h81, 4'h1, 1'b0);
    chk("host bytes taken", 16'd2, 16'(nt));
    rng("seek cycles", 15, 40, nk);
    chk("cylinder", 16'h0037, {8'h00, seek_cylinder});
    chk("gap2 normal", 16'h0016, {8'h00, gap2_length});
    rd(4'hD);
    chk("crc low", {8'h00, crc_of(2)[7:0]}, {8'h00, v});
    rd(4'hE);
    chk("crc high", {8'h00, crc_of(2)[15:8]}, {8'h00, v});
    $display("test write_pad done");
  endtask
  task automatic test_verify_count();
    setup(8'h00, 8'h02, 8'h01, 8'h09, 8'h03, 8'h00, 8'h00, 8'h03);
    run_cmd(8'h82, 4'h8, 1'b0);
    chk("verify gaps", 16'd1, 16'(ng));
    chk("verify host bytes", 16'd0, 16'(nv + nt));
    $display("test verify_count done");
  endtask
  initial begin
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    test_reset();
    test_read_multi();
    test_read_large();
    test_write_pad();
    test_verify_count();
    finish_test();
  end
endmodule
